// file: common/clock_power_pkg.sv
// Constants, register map and carrier types of the clock and power-mode manager.
// Assumes a single 125 MHz system clock and a plain strobe-based register port.
package clock_power_pkg;

    // Register port geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets.
    localparam logic [3:0] OFS_CLKS = 4'h0;
    localparam logic [3:0] OFS_OSC = 4'h1;
    localparam logic [3:0] OFS_PLL = 4'h2;
    localparam logic [3:0] OFS_TRIM = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MODE = 4'h5;

    // Clock select register fields.
    localparam int CLKS_BUS_FROM_PLL = 7;
    localparam int CLKS_PSEUDO_STOP_SEL = 6;
    localparam int CLKS_WD_STOP_CLK_DIS = 5;
    localparam int CLKS_WD_SEL_HIGH = 4;
    localparam int CLKS_PT_PSEUDO_EN = 3;
    localparam int CLKS_WD_PSEUDO_EN = 2;
    localparam int CLKS_PT_CLK_SEL = 1;
    localparam int CLKS_WD_SEL_LOW = 0;
    localparam logic [7:0] CLKS_RESET = 8'h80;

    // Oscillator register fields.
    localparam int OSC_ENABLE_BIT = 7;
    localparam int OSC_REFERENCE_DIVIDER_LSB = 0;

    // PLL register fields and reset values (50 MHz oscillator on a 1 MHz reference).
    localparam int PLL_MULT_LSB = 0;
    localparam int PLL_POSTDIV_LSB = 8;
    localparam logic [7:0] PLL_MULT_RESET = 8'h32;
    localparam logic [4:0] POSTDIV_RESET = 5'h03;

    // Status register fields.
    localparam int ST_OSC_UP = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_LOCK_FLAG = 2;
    localparam int ST_LOCK_IE = 3;
    localparam int ST_CAUSE_LSB = 8;

    // Timing.
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESET_HOLD_NS = 64;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SWITCH_GAP_NS = 16;
    localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Power modes.
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_FULL_STOP = 2'b01,
        MODE_PSEUDO_STOP = 2'b10
    } power_mode_t;

    // Counter clock sources.
    typedef enum logic [1:0] {
        SRC_IRC = 2'b00,
        SRC_OSC = 2'b01,
        SRC_RC = 2'b10
    } clk_src_t;

    // Register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    // System reset sources, all active high.
    typedef struct packed {
        logic power_on;
        logic low_voltage;
        logic illegal_addr;
        logic watchdog_timeout;
        logic clock_monitor_fail;
        logic ext_pin;
    } reset_src_t;

endpackage : clock_power_pkg

// file: logic/bus_clock_switch.sv
// Break-before-make gate sequencer for the bus clock switch.
// Assumes the gate outputs drive per-source clock gates in the clock tree.
`timescale 1ns/1ps
module bus_clock_switch #(
    parameter int GAP_CYC = clock_power_pkg::SWITCH_GAP_CYC
) (
    input wire logic clk_i, // System clock.
    input wire logic reset_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable.
    input wire logic sel_pll_i, // Wanted source: 1 PLL, 0 crystal.
    input wire logic pll_ready_i, // PLL output is running.
    input wire logic osc_ready_i, // Crystal clock is up.
    output logic pll_gate_o, // PLL clock gate open.
    output logic osc_gate_o // Crystal clock gate open.
);

    // Elaboration check: the gap must fit the 8-bit counter.
    if (GAP_CYC < 1 || GAP_CYC > 255) begin : g_gap_check
        $error("GAP_CYC out of range");
    end

    typedef struct packed {
        logic pll_gate;
        logic osc_gate;
        logic [7:0] gap;
    } sw_state_t;

    sw_state_t q;
    sw_state_t d;

    // Closes the active gate, waits the gap, then opens the new one once ready.
    always_comb begin
        d = q;
        if (ce_i) begin
            if ((q.pll_gate && !sel_pll_i) || (q.osc_gate && sel_pll_i)) begin
                d.pll_gate = 1'b0;
                d.osc_gate = 1'b0;
                d.gap = 8'(GAP_CYC);
            end else if (q.gap != 8'h00) begin
                d.gap = q.gap - 8'h01;
            end else if (!q.pll_gate && !q.osc_gate) begin
                d.pll_gate = sel_pll_i && pll_ready_i;
                d.osc_gate = !sel_pll_i && osc_ready_i;
            end
        end
    end

    // State register; PLL gate open from reset.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '{pll_gate: 1'b1, osc_gate: 1'b0, gap: 8'h00};
        end else begin
            q <= d;
        end
    end

    assign pll_gate_o = q.pll_gate;
    assign osc_gate_o = q.osc_gate;

    // Both gates are never open together.
    property p_no_overlap;
        @(posedge clk_i) disable iff (reset_i) !(pll_gate_o && osc_gate_o);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both clock gates open");

endmodule : bus_clock_switch

// file: logic/clock_mode_power_manager.sv
// Clock source, power mode, reset source and trim manager.
// Assumes one 125 MHz clock, synchronous inputs and a strobe register port.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module clock_mode_power_manager #(
    parameter int TRIM_W = 14,
    parameter int RESET_HOLD = clock_power_pkg::RESET_HOLD_CYC
) (
    input wire logic clk_i, // System clock.
    input wire logic reset_i, // Synchronous reset, active high.
    input wire logic ce_i, // Clock enable; low freezes all state.
    input wire clock_power_pkg::reg_req_t req_i, // Register port request.
    output logic [clock_power_pkg::DATA_W-1:0] rdata_o, // Read data, cycle after read.
    input wire logic stop_i, // CPU executes its stop instruction.
    input wire logic wake_i, // Wake-up event out of stop.
    input wire logic pll_lock_i, // PLL lock detector.
    input wire logic osc_up_i, // Crystal oscillator is up.
    input wire clock_power_pkg::reset_src_t reset_src_i, // Reset sources.
    input wire logic trim_valid_i, // Factory trim word from flash valid.
    input wire logic [TRIM_W-1:0] trim_value_i, // Factory trim word.
    output logic [TRIM_W-1:0] internal_ref_trim_o, // Reference trim value.
    output logic system_reset_o, // System reset request.
    output logic pll_enable_o, // PLL powered.
    output logic irc_enable_o, // Internal 1 MHz reference powered.
    output logic oscillator_active_o, // Crystal oscillator powered.
    output logic core_clocks_run_o, // Core, bus and debug clocks running.
    output logic lv_monitor_enable_o, // Low-voltage interrupt and reset enabled.
    output logic full_performance_o, // Regulator in full performance.
    output logic pll_gate_o, // Bus clock from PLL output.
    output logic osc_gate_o, // Bus clock from crystal clock.
    output logic pll_ref_external_o, // PLL reference from crystal.
    output logic [7:0] pll_mult_o, // PLL multiplier.
    output logic [4:0] pll_postdiv_o, // PLL post divider.
    output logic [3:0] reference_divider_o, // Crystal reference divider.
    output logic watchdog_count_en_o, // Watchdog counter runs.
    output clock_power_pkg::clk_src_t watchdog_src_o, // Watchdog clock source.
    output logic periodic_count_en_o, // Periodic timer counter runs.
    output clock_power_pkg::clk_src_t periodic_src_o, // Periodic timer clock source.
    output logic lock_irq_o // Lock change interrupt request.
);

    // Elaboration check: trim fits the data word, the hold fits its 8-bit counter.
    if (TRIM_W < 1 || TRIM_W > 16
            || RESET_HOLD < 1 || RESET_HOLD > 255) begin : g_param_check
        $error("parameter out of range");
    end

    typedef struct packed {
        clock_power_pkg::power_mode_t mode;
        logic [7:0] clks;
        logic osc_en;
        logic [3:0] ref_div;
        logic [7:0] pll_mult;
        logic [4:0] post_div;
        logic [TRIM_W-1:0] trim;
        logic trim_loaded;
        logic lock;
        logic lock_flag;
        logic lock_ie;
        logic osc_up;
        logic [5:0] causes;
        logic [7:0] hold;
        logic sys_reset;
        logic [clock_power_pkg::DATA_W-1:0] rdata;
        logic irq;
        logic pll_en;
        logic irc_en;
        logic osc_on;
        logic clocks_run;
        logic lv_en;
        logic wd_en;
        clock_power_pkg::clk_src_t wd_src;
        logic pt_en;
        clock_power_pkg::clk_src_t pt_src;
    } state_t;

    state_t q;
    state_t d;
    logic any_reset;
    logic [5:0] src_vec;

    // Register write predicate shared by every writable register.
    function automatic logic wr_hit(input clock_power_pkg::reg_req_t r, input logic [3:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    // Low-voltage reset only counts while the monitors are enabled.
    always_comb begin
        src_vec = reset_src_i;
        if (q.mode != clock_power_pkg::MODE_RUN) begin
            src_vec[4] = 1'b0;
        end
        any_reset = |src_vec;
    end

    // Next-state logic for mode, registers, flags and derived controls.
    always_comb begin
        d = q;
        if (ce_i) begin
            // Software writes; wait mode needs no state of its own.
            if (wr_hit(req_i, clock_power_pkg::OFS_CLKS)) begin
                d.clks = req_i.wdata[7:0];
            end
            if (wr_hit(req_i, clock_power_pkg::OFS_OSC)) begin
                d.osc_en = req_i.wdata[clock_power_pkg::OSC_ENABLE_BIT];
                d.ref_div = req_i.wdata[clock_power_pkg::OSC_REFERENCE_DIVIDER_LSB +: 4];
            end
            if (wr_hit(req_i, clock_power_pkg::OFS_PLL)) begin
                d.pll_mult = req_i.wdata[clock_power_pkg::PLL_MULT_LSB +: 8];
                d.post_div = req_i.wdata[clock_power_pkg::PLL_POSTDIV_LSB +: 5];
            end
            // Factory trim loads once after reset; a software write wins afterwards.
            if (wr_hit(req_i, clock_power_pkg::OFS_TRIM)) begin
                d.trim = req_i.wdata[TRIM_W-1:0];
                d.trim_loaded = 1'b1;
            end else if (!q.trim_loaded && trim_valid_i) begin
                d.trim = trim_value_i;
                d.trim_loaded = 1'b1;
            end
            // Status clears first so a simultaneous event still sets its flag.
            if (wr_hit(req_i, clock_power_pkg::OFS_STATUS)) begin
                if (req_i.wdata[clock_power_pkg::ST_LOCK_FLAG]) begin
                    d.lock_flag = 1'b0;
                end
                d.lock_ie = req_i.wdata[clock_power_pkg::ST_LOCK_IE];
                d.causes = q.causes & ~req_i.wdata[clock_power_pkg::ST_CAUSE_LSB +: 6];
            end
            d.osc_up = osc_up_i;
            d.lock = pll_lock_i;
            if (pll_lock_i != q.lock) begin
                d.lock_flag = 1'b1;
            end
            d.irq = d.lock_flag && d.lock_ie;

            // System reset request stretched to a fixed length.
            d.causes = d.causes | src_vec;
            if (any_reset) begin
                d.hold = 8'(RESET_HOLD - 1);
                d.sys_reset = 1'b1;
            end else if (q.hold != 8'h00) begin
                d.hold = q.hold - 8'h01;
                d.sys_reset = 1'b1;
            end else begin
                d.sys_reset = 1'b0;
            end

            // Power-mode sequencing.
            case (q.mode)
                clock_power_pkg::MODE_RUN: begin
                    if (stop_i) begin
                        if (q.clks[clock_power_pkg::CLKS_PSEUDO_STOP_SEL] && q.osc_en) begin
                            d.mode = clock_power_pkg::MODE_PSEUDO_STOP;
                        end else begin
                            d.mode = clock_power_pkg::MODE_FULL_STOP;
                        end
                    end
                end
                clock_power_pkg::MODE_FULL_STOP: begin
                    if (wake_i) begin
                        d.mode = clock_power_pkg::MODE_RUN;
                        d.clks[clock_power_pkg::CLKS_BUS_FROM_PLL] = 1'b1;
                        d.clks[clock_power_pkg::CLKS_WD_SEL_LOW] = 1'b0;
                        d.clks[clock_power_pkg::CLKS_PT_CLK_SEL] = 1'b0;
                    end
                end
                clock_power_pkg::MODE_PSEUDO_STOP: begin
                    if (wake_i) begin
                        d.mode = clock_power_pkg::MODE_RUN;
                    end
                end
                default: begin
                    d.mode = clock_power_pkg::MODE_RUN;
                end
            endcase

            // Clock and power controls follow the next mode.
            d.pll_en = (d.mode == clock_power_pkg::MODE_RUN);
            d.irc_en = (d.mode == clock_power_pkg::MODE_RUN);
            d.clocks_run = (d.mode == clock_power_pkg::MODE_RUN);
            d.lv_en = (d.mode == clock_power_pkg::MODE_RUN);
            d.osc_on = d.osc_en && (d.mode != clock_power_pkg::MODE_FULL_STOP);

            // Watchdog clocking.
            if (d.clks[clock_power_pkg::CLKS_WD_SEL_HIGH]) begin
                d.wd_src = clock_power_pkg::SRC_RC;
                d.wd_en = (d.mode == clock_power_pkg::MODE_RUN)
                    || !d.clks[clock_power_pkg::CLKS_WD_STOP_CLK_DIS];
            end else if (d.mode == clock_power_pkg::MODE_PSEUDO_STOP) begin
                d.wd_src = clock_power_pkg::SRC_OSC;
                d.wd_en = d.clks[clock_power_pkg::CLKS_WD_PSEUDO_EN];
            end else begin
                d.wd_src = d.clks[clock_power_pkg::CLKS_WD_SEL_LOW] ?
                    clock_power_pkg::SRC_OSC : clock_power_pkg::SRC_IRC;
                d.wd_en = (d.mode == clock_power_pkg::MODE_RUN);
            end

            // Periodic timer clocking.
            if (d.mode == clock_power_pkg::MODE_PSEUDO_STOP) begin
                d.pt_src = clock_power_pkg::SRC_OSC;
                d.pt_en = d.clks[clock_power_pkg::CLKS_PT_PSEUDO_EN];
            end else begin
                d.pt_src = d.clks[clock_power_pkg::CLKS_PT_CLK_SEL] ?
                    clock_power_pkg::SRC_OSC : clock_power_pkg::SRC_IRC;
                d.pt_en = (d.mode == clock_power_pkg::MODE_RUN);
            end

            // Read data stand only in the cycle after the read strobe.
            d.rdata = '0;
            if (req_i.rd) begin
                case (req_i.addr)
                    clock_power_pkg::OFS_CLKS: d.rdata[7:0] = q.clks;
                    clock_power_pkg::OFS_OSC: begin
                        d.rdata[clock_power_pkg::OSC_ENABLE_BIT] = q.osc_en;
                        d.rdata[clock_power_pkg::OSC_REFERENCE_DIVIDER_LSB +: 4] = q.ref_div;
                    end
                    clock_power_pkg::OFS_PLL: begin
                        d.rdata[clock_power_pkg::PLL_MULT_LSB +: 8] = q.pll_mult;
                        d.rdata[clock_power_pkg::PLL_POSTDIV_LSB +: 5] = q.post_div;
                    end
                    clock_power_pkg::OFS_TRIM: d.rdata[TRIM_W-1:0] = q.trim;
                    clock_power_pkg::OFS_STATUS: begin
                        d.rdata[clock_power_pkg::ST_OSC_UP] = q.osc_up;
                        d.rdata[clock_power_pkg::ST_LOCK] = q.lock;
                        d.rdata[clock_power_pkg::ST_LOCK_FLAG] = q.lock_flag;
                        d.rdata[clock_power_pkg::ST_LOCK_IE] = q.lock_ie;
                        d.rdata[clock_power_pkg::ST_CAUSE_LSB +: 6] = q.causes;
                    end
                    clock_power_pkg::OFS_MODE: d.rdata[1:0] = q.mode;
                    default: d.rdata = '0;
                endcase
            end
        end
    end

    // State register with the reset image: PLL mode on the internal reference.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.mode <= clock_power_pkg::MODE_RUN;
            q.clks <= clock_power_pkg::CLKS_RESET;
            q.pll_mult <= clock_power_pkg::PLL_MULT_RESET;
            q.post_div <= clock_power_pkg::POSTDIV_RESET;
            q.pll_en <= 1'b1;
            q.irc_en <= 1'b1;
            q.clocks_run <= 1'b1;
            q.lv_en <= 1'b1;
            q.wd_en <= 1'b1;
            q.pt_en <= 1'b1;
            q.wd_src <= clock_power_pkg::SRC_IRC;
            q.pt_src <= clock_power_pkg::SRC_IRC;
        end else begin
            q <= d;
        end
    end

    // Glitch-free switch between PLL output and crystal clock.
    bus_clock_switch #(
        .GAP_CYC(clock_power_pkg::SWITCH_GAP_CYC)
    ) u_switch (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .sel_pll_i(q.clks[clock_power_pkg::CLKS_BUS_FROM_PLL]),
        .pll_ready_i(q.pll_en),
        .osc_ready_i(q.osc_up && q.osc_on),
        .pll_gate_o(pll_gate_o),
        .osc_gate_o(osc_gate_o)
    );

    // Outputs straight from the state register.
    assign rdata_o = q.rdata;
    assign internal_ref_trim_o = q.trim;
    assign system_reset_o = q.sys_reset;
    assign pll_enable_o = q.pll_en;
    assign irc_enable_o = q.irc_en;
    assign oscillator_active_o = q.osc_on;
    assign core_clocks_run_o = q.clocks_run;
    assign lv_monitor_enable_o = q.lv_en;
    assign full_performance_o = q.clocks_run;
    assign pll_ref_external_o = q.osc_en;
    assign pll_mult_o = q.pll_mult;
    assign pll_postdiv_o = q.post_div;
    assign reference_divider_o = q.ref_div;
    assign watchdog_count_en_o = q.wd_en;
    assign watchdog_src_o = q.wd_src;
    assign periodic_count_en_o = q.pt_en;
    assign periodic_src_o = q.pt_src;
    assign lock_irq_o = q.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // Checks on the mode, clock and reset behaviour.
    property p_reset_mode;
        $fell(reset_i) |-> q.mode == clock_power_pkg::MODE_RUN && pll_gate_o && !q.osc_en;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("not in PLL mode after reset");
    property p_reset_pll;
        $fell(reset_i) |-> pll_mult_o == 8'h32 && pll_postdiv_o == 5'h03;
    endproperty
    a_reset_pll: assert property (p_reset_pll) else $error("PLL reset values wrong");
    property p_stop_off;
        ce_i && q.mode == clock_power_pkg::MODE_RUN && stop_i
            |=> !pll_enable_o && !irc_enable_o && !core_clocks_run_o && !lv_monitor_enable_o;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop left sources on");
    property p_stop_choice;
        ce_i && q.mode == clock_power_pkg::MODE_RUN && stop_i |=> q.mode ==
            (($past(q.clks[6]) && $past(q.osc_en)) ? clock_power_pkg::MODE_PSEUDO_STOP
            : clock_power_pkg::MODE_FULL_STOP);
    endproperty
    a_stop_choice: assert property (p_stop_choice) else $error("wrong stop variant");
    property p_full_stop;
        q.mode == clock_power_pkg::MODE_FULL_STOP |-> !oscillator_active_o && !periodic_count_en_o
            && (q.clks[4] || !watchdog_count_en_o);
    endproperty
    a_full_stop: assert property (p_full_stop) else $error("full stop left clocks on");
    property p_full_wake;
        ce_i && q.mode == clock_power_pkg::MODE_FULL_STOP && wake_i
            |=> q.clks[7] && !q.clks[1] && !q.clks[0] && q.mode == clock_power_pkg::MODE_RUN;
    endproperty
    a_full_wake: assert property (p_full_wake) else $error("wake selects wrong");
    property p_pseudo_keep;
        q.mode == clock_power_pkg::MODE_PSEUDO_STOP && !req_i.wr |=> $stable(q.clks)
            && (q.mode != clock_power_pkg::MODE_PSEUDO_STOP || oscillator_active_o);
    endproperty
    a_pseudo_keep: assert property (p_pseudo_keep) else $error("pseudo stop changed");
    property p_lock_flag;
        ce_i && pll_lock_i != q.lock |=> q.lock_flag && (!q.lock_ie || lock_irq_o);
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock change not flagged");
    property p_reset_hold;
        ce_i && reset_src_i.power_on |=> system_reset_o [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset request too short");

    c_pseudo: cover property (q.mode == clock_power_pkg::MODE_PSEUDO_STOP);
    c_full_wake: cover property (q.mode == clock_power_pkg::MODE_FULL_STOP ##1
        q.mode == clock_power_pkg::MODE_RUN);
    c_lock_irq: cover property ($rose(lock_irq_o));
    c_osc_bus: cover property ($rose(osc_gate_o));

endmodule : clock_mode_power_manager

// file: verif/osc_pll_model.sv
// Far-side model of the crystal oscillator start-up and the PLL lock detector.
// Assumes power enables arrive as levels synchronous to the system clock.
`timescale 1ns/1ps
module osc_pll_model (
    input wire logic clk_i, // System clock.
    input wire logic osc_on_i, // Oscillator powered.
    input wire logic pll_on_i, // PLL powered.
    output logic osc_up_o, // Oscillator started.
    output logic lock_o // PLL locked.
);
    logic [4:0] osc_q = '0;
    logic [4:0] pll_q = '0;
    // Start-up counters saturate; losing power drops the flag at once.
    always_ff @(posedge clk_i) begin
        osc_q <= (osc_on_i === 1'b1) ? osc_q + {4'h0, ~&osc_q} : '0;
        pll_q <= (pll_on_i === 1'b1) ? pll_q + {4'h0, ~&pll_q} : '0;
    end
    assign osc_up_o = &osc_q;
    assign lock_o = &pll_q;
endmodule : osc_pll_model

// file: verif/clock_mode_power_manager_tb.sv
// Self-checking bench of the clock and power-mode manager.
// Assumes the oscillator and PLL model drives the up and lock inputs.
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
$display("wrong value %s exp %h got %h", n, e, s); end end
module clock_mode_power_manager_tb;
    logic clk_i = 0, reset_i = 1, stop_i = 0, wake_i = 0, trim_valid_i = 0;
    logic pll_lock_i, osc_up_i, system_reset_o, pll_enable_o, irc_enable_o, core_clocks_run_o;
    logic oscillator_active_o, lv_monitor_enable_o, pll_gate_o, osc_gate_o, pll_ref_external_o;
    logic watchdog_count_en_o, periodic_count_en_o, lock_irq_o, full_performance_o;
    logic ce_i = 1'b1;
    logic [3:0] reference_divider_o;
    logic [13:0] trim_value_i = '0, internal_ref_trim_o;
    logic [15:0] rdata_o, rd;
    logic [7:0] pll_mult_o;
    logic [4:0] pll_postdiv_o;
    clock_power_pkg::clk_src_t watchdog_src_o, periodic_src_o;
    clock_power_pkg::reg_req_t req_i = '0;
    clock_power_pkg::reset_src_t reset_src_i = '0;
    int errors = 0, compares = 0;
    logic [15:0] pc [2] = '{16'h4F2D, 16'h7C15};
    wire [4:0] run = {pll_enable_o, irc_enable_o, core_clocks_run_o, lv_monitor_enable_o,
        full_performance_o};
    wire [5:0] cnt = {watchdog_count_en_o, watchdog_src_o, periodic_count_en_o, periodic_src_o};
    // Design with its far-side oscillator and PLL model.
    clock_mode_power_manager u_clock_mode_power_manager (.*);
    osc_pll_model u_osc_pll_model (.clk_i, .osc_on_i(oscillator_active_o),
        .pll_on_i(pll_enable_o), .osc_up_o(osc_up_i), .lock_o(pll_lock_i));
    // Clock and watchdog.
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    task automatic give_verdict;
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i) req_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i) req_i <= '0;
    endtask : wr
    task automatic rdreg(input logic [3:0] a);
        @(posedge clk_i) req_i <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk_i) req_i <= '0;
        @(negedge clk_i) rd = rdata_o;
    endtask : rdreg
    task automatic pulse(input bit w);
        @(posedge clk_i) {wake_i, stop_i} <= w ? 2'b10 : 2'b01;
        @(posedge clk_i) {wake_i, stop_i} <= 2'b00;
        repeat (2) @(negedge clk_i);
    endtask : pulse
    task automatic wait_up;
        for (int i = 0; i < 200 && osc_up_i !== 1'b1; i++) @(posedge clk_i);
    endtask : wait_up
    // Main sequence: reset state, trim, clock modes, stops and reset sources.
    initial begin
        void'($urandom(32'h5916A6AC));
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        `CHK("mult", 8'h32, pll_mult_o)
        `CHK("postdiv", 5'h03, pll_postdiv_o)
        `CHK("path", 3'b100, {pll_gate_o, osc_gate_o, pll_ref_external_o})
        @(posedge clk_i) {trim_valid_i, trim_value_i} <= {1'b1, 14'($urandom)};
        @(posedge clk_i) trim_valid_i <= 1'b0;
        @(negedge clk_i);
        `CHK("trim", trim_value_i, internal_ref_trim_o)
        wr(clock_power_pkg::OFS_TRIM, {2'b00, ~trim_value_i});
        @(negedge clk_i);
        `CHK("trim_wr", ~trim_value_i, internal_ref_trim_o)
        wr(clock_power_pkg::OFS_PLL, 16'h0A19);
        wr(clock_power_pkg::OFS_OSC, 16'h0085);
        @(negedge clk_i);
        `CHK("pll_cfg", 18'h2A195, {pll_ref_external_o, pll_postdiv_o, pll_mult_o, reference_divider_o})
        wait_up();
        rdreg(clock_power_pkg::OFS_STATUS);
        `CHK("status", 4'b0111, rd[3:0])
        wr(clock_power_pkg::OFS_STATUS, 16'h000C);
        wr(clock_power_pkg::OFS_CLKS, 16'h0000);
        repeat (5) @(negedge clk_i);
        `CHK("bypass", 4'b0110, {pll_gate_o, osc_gate_o, pll_enable_o, lock_irq_o})
        wr(clock_power_pkg::OFS_CLKS, 16'h0003);
        pulse(1'b0);
        `CHK("stop_run", 5'h00, run)
        `CHK("stop_cnt", 3'b000, {oscillator_active_o, cnt[5], cnt[2]})
        @(posedge clk_i) reset_src_i <= 6'h10;
        @(posedge clk_i) reset_src_i <= 6'h00;
        repeat (3) @(negedge clk_i);
        `CHK("lv_irq", 2'b01, {system_reset_o, lock_irq_o})
        pulse(1'b1);
        `CHK("wake_run", 5'h1F, run)
        rdreg(clock_power_pkg::OFS_CLKS);
        `CHK("wake_clks", 8'h80, rd[7:0])
        foreach (pc[i]) begin
            wait_up();
            wr(clock_power_pkg::OFS_CLKS, {8'h00, pc[i][15:8]});
            pulse(1'b0);
            `CHK("ps", {1'b1, pc[i][5:0]}, {oscillator_active_o, cnt})
            pulse(1'b1);
            rdreg(clock_power_pkg::OFS_CLKS);
            `CHK("ps_clks", pc[i][15:8], rd[7:0])
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_i) reset_src_i <= 6'(1 << i);
            @(posedge clk_i) reset_src_i <= 6'h00;
            @(negedge clk_i);
            `CHK("sys_reset", 1'b1, system_reset_o)
            repeat (12) @(negedge clk_i);
            `CHK("sys_release", 1'b0, system_reset_o)
        end
        rdreg(clock_power_pkg::OFS_STATUS);
        `CHK("causes", 6'h3F, rd[13:8])
        // Full stop with the watchdog on the RC clock, then wake-up selects.
        wr(clock_power_pkg::OFS_CLKS, 16'h0010);
        pulse(1'b0);
        `CHK("fs_rc", 7'h30, {oscillator_active_o, cnt})
        pulse(1'b1);
        `CHK("fs_wake", 6'h34, cnt)
        // A stop request while the clock enable is low must be ignored.
        @(posedge clk_i) {ce_i, stop_i} <= 2'b01;
        @(posedge clk_i) {ce_i, stop_i} <= 2'b10;
        repeat (2) @(negedge clk_i);
        `CHK("ce_hold", 5'h1F, run)
        give_verdict();
    end
endmodule : clock_mode_power_manager_tb
